// ===== shared/fwp_pkg.sv
// Constants, field layouts and carrier types of the flash write-protect control block.
package fwp_pkg;

  // Transfer framing.
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [8:0] ONE_BYTE = 9'h001;
  localparam logic [8:0] STATUS_WRITE_BYTES = 9'h002;
  localparam logic [8:0] HEADER_BYTES = 9'h004;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [8:0] COUNT_MAX = 9'h1FF;

  // Status byte layout.
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP0 = 2;
  localparam int BP_BITS = 4;
  localparam int ST_STATUS_WRITE_DISABLE = 7;
  localparam logic [3:0] BP_MASK_LARGE = 4'h7;
  localparam logic [3:0] BP_MASK_SMALL = 4'hF;

  // Array geometry used by the protected-region decode.
  localparam logic [24:0] ARRAY_BYTES = 25'h1000000;
  localparam logic [24:0] LARGE_SECTOR_BYTES = 25'h0040000;
  localparam logic [24:0] SMALL_PAIR_BYTES = 25'h0020000;

  // Default command codes; the values are arbitrary.
  localparam logic [7:0] DEF_WRITE_ENABLE_CMD = 8'h11;
  localparam logic [7:0] DEF_WRITE_DISABLE_CMD = 8'h12;
  localparam logic [7:0] DEF_PAGE_PROGRAM_CMD = 8'h13;
  localparam logic [7:0] DEF_SECTOR_ERASE_CMD = 8'h14;
  localparam logic [7:0] DEF_BULK_ERASE_CMD = 8'h15;
  localparam logic [7:0] DEF_WRITE_STATUS_CMD = 8'h16;
  localparam logic [7:0] DEF_READ_STATUS_CMD = 8'h17;
  localparam logic [7:0] DEF_DEEP_POWER_DOWN_CMD = 8'h18;

  // Array operations handed to the array side.
  typedef enum logic [2:0] {
    FWP_PROG_BYTE,
    FWP_COMMIT,
    FWP_ABORT,
    FWP_SECTOR_ERASE,
    FWP_BULK_ERASE
  } fwp_kind_type;

  typedef struct packed {
    fwp_kind_type kind;
    logic [ADDR_BITS-1:0] addr;
    logic [BYTE_BITS-1:0] data;
  } fwp_op_type;

  // Frame phases of the serial decoder.
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_READ, PH_SKIP} fwp_phase_type;

  // Tells whether an address lies in the top-aligned block-protected region.
  function automatic logic fwp_is_protected(input logic [ADDR_BITS-1:0] a,
                                            input logic [3:0] bp,
                                            input logic small_sect);
    logic [24:0] size;
    logic [2:0] lvl;
    lvl = bp[2:0];
    size = '0;
    if (small_sect) begin
      if (bp[3]) begin
        size = ARRAY_BYTES;
      end else if (lvl != '0) begin
        size = SMALL_PAIR_BYTES << (lvl - 3'h1);
      end
    end else if (lvl != '0) begin
      size = LARGE_SECTOR_BYTES << (lvl - 3'h1);
    end
    return (size != '0) && ({1'b0, a} >= (ARRAY_BYTES - size));
  endfunction

endpackage

// ===== rtl/fwp_fifo.sv
// Parameterised FIFO with a registered read word and valid/ready on both sides.
`timescale 1ns/1ps
module fwp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  import fwp_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  wire logic push;
  wire logic pop;
  wire logic [PTR_W-1:0] rd_view;

  // Handshake decode; the depth is a power of two so pointers wrap naturally.
  assign in_ready_o = (count != FULL_COUNT);
  assign out_valid_o = (count != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign rd_view = pop ? rd_ptr + 1'b1 : rd_ptr;

  // Storage array, written without reset.
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers, fill level and the read word that always shows the head entry.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_data_o <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= rd_view;
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
      out_data_o <= (push && (wr_ptr == rd_view)) ? in_data_i : mem[rd_view];
    end
  end

endmodule

// ===== rtl/fwp_ctrl.sv
// Serial flash command decoder with write-enable latch, block protection and busy tracking.
//
// Function
// [R01] Host may drive serial clock in mode 0 or mode 3 only.
// [R02] Input bits are taken on rising clock edges, output driven from falling edges.
// [R03] Host parks the serial clock low in mode 0, high in mode 3.
// [R04] Every command, address and data transfer is whole eight-bit bytes.
// [R05] Host sends write-enable, then program opcode, three address bytes, then data.
// [R06] One page program accepts one to 256 data bytes.
// [R07] Programming only clears bits; only erase returns bits to one.
// [R08] Sector erase sets a sector to ones, bulk erase the whole array.
// [R09] Busy flag shows a running status write, program or erase; host polls it.
// [R10] Active while selected or busy, standby otherwise.
// [R11] After deep power down, program and erase commands are ignored.
// [R12] Write-enable sets the latch; modifying commands are rejected while it is clear.
// [R13] Latch clears at reset and on program, erase, write-disable, status write completion.
// [R14] Block-protect field is nonvolatile: three bits large-sector, four bits small-sector.
// [R15] Large-sector codes double a top region from one sector up to the whole array.
// [R16] Small-sector codes start at two top sectors; top bit set protects everything.
// [R17] Protected addresses stay readable but program and erase leave them untouched.
// [R18] Disable bit set with protect pin low freezes disable and block-protect bits.
// [R19] Program, erase and status write run only on a whole number of bytes.
// [R20] No command before a chip-select fall after reset; output released when deselected.
// [R21] Busy rises when an operation starts and clears with the latch on completion.
`timescale 1ns/1ps
module fwp_ctrl #(
  parameter logic SMALL_SECTOR = 1'b0,
  parameter logic [7:0] NV_INIT = 8'h00,
  parameter logic [7:0] WRITE_ENABLE_CMD = fwp_pkg::DEF_WRITE_ENABLE_CMD,
  parameter logic [7:0] WRITE_DISABLE_CMD = fwp_pkg::DEF_WRITE_DISABLE_CMD,
  parameter logic [7:0] PAGE_PROGRAM_CMD = fwp_pkg::DEF_PAGE_PROGRAM_CMD,
  parameter logic [7:0] SECTOR_ERASE_CMD = fwp_pkg::DEF_SECTOR_ERASE_CMD,
  parameter logic [7:0] BULK_ERASE_CMD = fwp_pkg::DEF_BULK_ERASE_CMD,
  parameter logic [7:0] WRITE_STATUS_CMD = fwp_pkg::DEF_WRITE_STATUS_CMD,
  parameter logic [7:0] READ_STATUS_CMD = fwp_pkg::DEF_READ_STATUS_CMD,
  parameter logic [7:0] DEEP_POWER_DOWN_CMD = fwp_pkg::DEF_DEEP_POWER_DOWN_CMD
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic write_protect_accel_n_i,
  output logic so_o,
  output logic so_oe_o,
  output logic op_valid_o,
  input wire logic op_ready_i,
  output fwp_pkg::fwp_op_type op_o,
  input wire logic array_done_i,
  output logic [7:0] status_o,
  output logic power_active_o,
  output logic deep_power_down_o
);
  import fwp_pkg::*;

  logic cs_s1, cs_s2, cs_s3;
  logic sck_s1, sck_s2, sck_s3;
  logic si_s1, si_s2;
  logic pin_s1, pin_s2;
  logic armed;
  fwp_phase_type phase, next_phase;
  logic [2:0] bit_cnt;
  logic [8:0] byte_cnt;
  logic [8:0] data_cnt;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] status_val;
  logic [7:0] shift_out;
  logic [2:0] out_cnt;
  logic prog_ok, overflow;
  logic busy, write_enable_latch_bit, status_write_disable, st_pend, dp_lock;
  logic [3:0] bp;
  logic [7:0] status;
  logic end_valid;
  fwp_op_type end_op;
  fwp_op_type fifo_in;
  logic fifo_ready;
  logic [$bits(fwp_op_type)-1:0] fifo_out;

  // Two-stage synchronisers for every pin; the third stages serve edge detection only.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {cs_s1, cs_s2, cs_s3} <= '0;
      {sck_s1, sck_s2, sck_s3} <= '0;
      {si_s1, si_s2, pin_s1, pin_s2} <= '0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {cs_n_i, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_s3} <= {sck_i, sck_s1, sck_s2};
      {si_s1, si_s2, pin_s1, pin_s2} <= {si_i, si_s1, write_protect_accel_n_i, pin_s1};
    end
  end

  // Frame qualifiers; a select held low through reset is never armed.
  wire logic selected = armed & ~cs_s2;
  wire logic frame_end = armed & cs_s2 & ~cs_s3;
  wire logic sck_rise = selected & sck_s2 & ~sck_s3; // [R01]
  wire logic sck_fall = selected & ~sck_s2 & sck_s3;
  wire logic byte_done = sck_rise & (bit_cnt == LAST_BIT);
  wire logic [7:0] byte_val = {shift_in[6:0], si_s2};
  wire logic [23:0] full_addr = {addr[15:0], byte_val};
  wire logic whole = (bit_cnt == '0);
  wire logic hw_protect_state = status_write_disable & ~pin_s2;
  wire logic [3:0] bp_mask = SMALL_SECTOR ? BP_MASK_SMALL : BP_MASK_LARGE;

  // Arming waits for chip select to be seen high after reset.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed <= 1'b0;
    end else begin
      armed <= armed | cs_s2; // [R20]
    end
  end

  // Next phase: opcode routes the frame, deselect always returns to idle.
  always_comb begin
    next_phase = phase;
    if (!selected) begin
      next_phase = PH_IDLE;
    end else if (byte_done) begin
      case (phase)
        PH_IDLE: begin
          if (byte_val == READ_STATUS_CMD) begin
            next_phase = PH_READ;
          end else if (byte_val == PAGE_PROGRAM_CMD || byte_val == SECTOR_ERASE_CMD) begin
            next_phase = PH_ADDR;
          end else if (byte_val == WRITE_STATUS_CMD) begin
            next_phase = PH_DATA;
          end else begin
            next_phase = PH_SKIP;
          end
        end
        PH_ADDR: begin
          if (byte_cnt == HEADER_BYTES - ONE_BYTE) begin
            next_phase = (opcode == PAGE_PROGRAM_CMD) ? PH_DATA : PH_SKIP;
          end
        end
        default: next_phase = phase;
      endcase
    end
  end

  // Bit and byte counters run on rising serial clock edges and clear on deselect.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PH_IDLE;
      bit_cnt <= '0;
      byte_cnt <= '0;
      shift_in <= '0;
    end else begin
      phase <= next_phase;
      if (!selected) begin
        bit_cnt <= '0;
        byte_cnt <= '0;
      end else if (sck_rise) begin
        shift_in <= byte_val; // [R02]
        bit_cnt <= bit_cnt + 3'h1; // [R04] [R19]
        if (byte_done && byte_cnt != COUNT_MAX) begin
          byte_cnt <= byte_cnt + 9'h001;
        end
      end
    end
  end

  // Opcode and address capture.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      opcode <= '0;
      addr <= '0;
    end else if (byte_done) begin
      if (phase == PH_IDLE) begin
        opcode <= byte_val;
      end else if (phase == PH_ADDR) begin
        addr <= full_addr;
      end else if (phase == PH_DATA && opcode == PAGE_PROGRAM_CMD) begin
        addr[7:0] <= addr[7:0] + 8'h01; // Column wraps inside the page.
      end
    end
  end

  // Page program data path: each accepted byte is offered to the buffer.
  wire logic header_done = byte_done & (phase == PH_ADDR) & (opcode == PAGE_PROGRAM_CMD)
                           & (byte_cnt == HEADER_BYTES - ONE_BYTE);
  wire logic header_ok = write_enable_latch_bit & ~busy & ~dp_lock
                         & ~fwp_is_protected(full_addr, bp, SMALL_SECTOR); // [R15] [R16]
  wire logic data_byte = byte_done & (phase == PH_DATA);
  wire logic prog_try = data_byte & prog_ok & (opcode == PAGE_PROGRAM_CMD)
                        & (data_cnt != PAGE_BYTES);
  wire logic data_push = prog_try & ~end_valid & fifo_ready;

  // Per-frame program bookkeeping, cleared whenever the device is deselected.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_ok <= 1'b0;
      overflow <= 1'b0;
      data_cnt <= '0;
      status_val <= '0;
    end else if (!selected) begin
      prog_ok <= 1'b0;
      overflow <= 1'b0;
      data_cnt <= '0;
    end else begin
      if (header_done) begin
        prog_ok <= header_ok; // [R11] [R12] [R17]
      end
      if (prog_try) begin
        data_cnt <= data_cnt + 9'h001; // [R06]
        overflow <= overflow | ~data_push;
      end
      if (data_byte && opcode == WRITE_STATUS_CMD && byte_cnt == ONE_BYTE) begin
        status_val <= byte_val;
      end
    end
  end

  // End-of-frame command decisions, taken on the rising edge of chip select.
  wire logic may_modify = frame_end & whole & write_enable_latch_bit & ~busy;
  wire logic write_enable_cmd_go = frame_end & whole & ~busy & (opcode == WRITE_ENABLE_CMD)
                       & (byte_cnt == ONE_BYTE);
  wire logic write_disable_cmd_go = frame_end & whole & ~busy & (opcode == WRITE_DISABLE_CMD)
                       & (byte_cnt == ONE_BYTE);
  wire logic write_status_cmd_go = may_modify & ~hw_protect_state & (opcode == WRITE_STATUS_CMD)
                       & (byte_cnt == STATUS_WRITE_BYTES);
  wire logic commit_go = frame_end & whole & prog_ok & ~overflow & (data_cnt != '0);
  wire logic abort_go = frame_end & prog_ok & (data_cnt != '0) & ~commit_go;
  wire logic sector_go = may_modify & ~dp_lock & (opcode == SECTOR_ERASE_CMD)
                         & (byte_cnt == HEADER_BYTES)
                         & ~fwp_is_protected(addr, bp, SMALL_SECTOR);
  wire logic bulk_go = may_modify & ~dp_lock & (opcode == BULK_ERASE_CMD)
                       & (byte_cnt == ONE_BYTE) & (bp == '0);
  wire logic dp_go = frame_end & whole & (opcode == DEEP_POWER_DOWN_CMD)
                     & (byte_cnt == ONE_BYTE);
  wire logic start_go = commit_go | sector_go | bulk_go | write_status_cmd_go;
  wire logic array_finish = array_done_i & busy & ~st_pend;
  wire logic op_finish = array_finish | st_pend;

  // Pending end-of-frame entry; it waits for buffer space and has priority.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      end_valid <= 1'b0;
      end_op <= '0;
    end else if (commit_go || abort_go || sector_go || bulk_go) begin
      end_valid <= 1'b1;
      end_op.addr <= addr;
      end_op.data <= '0;
      if (commit_go) begin
        end_op.kind <= FWP_COMMIT; // [R07] [R19]
      end else if (abort_go) begin
        end_op.kind <= FWP_ABORT; // [R19]
      end else if (sector_go) begin
        end_op.kind <= FWP_SECTOR_ERASE; // [R08] [R17]
      end else begin
        end_op.kind <= FWP_BULK_ERASE; // [R08]
      end
    end else if (end_valid && fifo_ready) begin
      end_valid <= 1'b0;
    end
  end

  // Buffer input selection between the pending entry and a program byte.
  always_comb begin
    fifo_in = end_op;
    if (!end_valid) begin
      fifo_in.kind = FWP_PROG_BYTE; // [R07]
      fifo_in.addr = addr;
      fifo_in.data = byte_val;
    end
  end

  wire logic fifo_push = end_valid | data_push;

  fwp_fifo #(
    .WIDTH($bits(fwp_op_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_op_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_in),
    .out_valid_o(op_valid_o),
    .out_ready_i(op_ready_i),
    .out_data_o(fifo_out)
  );

  assign op_o = fwp_op_type'(fifo_out);

  // Busy, latch and lockout; a latch set and a completion never coincide.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      write_enable_latch_bit <= 1'b0; // [R13]
      st_pend <= 1'b0;
      dp_lock <= 1'b0;
    end else begin
      st_pend <= write_status_cmd_go;
      dp_lock <= dp_lock | dp_go; // [R11]
      if (start_go) begin
        busy <= 1'b1; // [R09] [R21]
      end else if (op_finish) begin
        busy <= 1'b0; // [R21]
      end
      if (write_enable_cmd_go) begin
        write_enable_latch_bit <= 1'b1; // [R12]
      end else if (op_finish || write_disable_cmd_go) begin
        write_enable_latch_bit <= 1'b0; // [R13] [R21]
      end
    end
  end

  // Nonvolatile protection bits; frozen while hardware protection holds.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bp <= NV_INIT[ST_BP0 +: BP_BITS] & (SMALL_SECTOR ? BP_MASK_SMALL : BP_MASK_LARGE);
      status_write_disable <= NV_INIT[ST_STATUS_WRITE_DISABLE];
    end else if (write_status_cmd_go) begin
      bp <= status_val[ST_BP0 +: BP_BITS] & bp_mask; // [R14] [R18]
      status_write_disable <= status_val[ST_STATUS_WRITE_DISABLE];
    end
  end

  // Status byte as read back by the host.
  always_comb begin
    status = '0;
    status[ST_BUSY] = busy; // [R09]
    status[ST_WEL] = write_enable_latch_bit;
    status[ST_BP0 +: BP_BITS] = bp;
    status[ST_STATUS_WRITE_DISABLE] = status_write_disable;
  end

  // Status read-out shifts most significant bit first on falling clock edges.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      so_o <= 1'b0;
      shift_out <= '0;
      out_cnt <= '0;
    end else if (!selected) begin
      out_cnt <= '0;
    end else if (sck_fall && phase == PH_READ) begin
      out_cnt <= out_cnt + 3'h1;
      if (out_cnt == '0) begin
        so_o <= status[ST_STATUS_WRITE_DISABLE]; // [R02] [R09]
        shift_out <= {status[6:0], 1'b0};
      end else begin
        so_o <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  assign so_oe_o = selected & (phase == PH_READ); // [R20]
  assign status_o = status;
  assign power_active_o = selected | busy; // [R10]
  assign deep_power_down_o = dp_lock;

  // Checks of the behaviour above.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  wire logic push_modify = fifo_push & fifo_ready & (fifo_in.kind != FWP_ABORT);

  property p_release_out;
    !selected |-> !so_oe_o;
  endproperty
  a_release_out: assert property (p_release_out) else $error("Output driven while deselected."); // [R20]

  property p_finish_clears;
    array_finish |=> !busy && !write_enable_latch_bit;
  endproperty
  a_finish_clears: assert property (p_finish_clears) else $error("Completion left busy or latch."); // [R13]

  property p_busy_needs_latch;
    $rose(busy) |-> $past(write_enable_latch_bit) && $past(frame_end);
  endproperty
  a_busy_needs_latch: assert property (p_busy_needs_latch) else $error("Busy without latch."); // [R12]

  property p_status_write_done;
    write_status_cmd_go |=> busy ##1 !busy && !write_enable_latch_bit;
  endproperty
  a_status_write_done: assert property (p_status_write_done) else $error("Status write timing."); // [R21]

  property p_frozen;
    hw_protect_state |=> $stable(bp) && $stable(status_write_disable);
  endproperty
  a_frozen: assert property (p_frozen) else $error("Protect bits changed under hardware lock."); // [R18]

  property p_lockout;
    dp_lock && $past(dp_lock) |-> !(start_go && !write_status_cmd_go);
  endproperty
  a_lockout: assert property (p_lockout) else $error("Array operation after deep power down."); // [R11]

  property p_partial_byte;
    frame_end && !whole |-> !start_go;
  endproperty
  a_partial_byte: assert property (p_partial_byte) else $error("Partial byte frame executed."); // [R19]

  property p_region;
    push_modify && (fifo_in.kind == FWP_PROG_BYTE || fifo_in.kind == FWP_SECTOR_ERASE)
      |-> !fwp_is_protected(fifo_in.addr, bp, SMALL_SECTOR);
  endproperty
  a_region: assert property (p_region) else $error("Protected address sent to array."); // [R17]

  property p_bulk_clear;
    push_modify && fifo_in.kind == FWP_BULK_ERASE |-> bp == '0;
  endproperty
  a_bulk_clear: assert property (p_bulk_clear) else $error("Bulk erase with protection set."); // [R17]

  property p_page_size;
    commit_go |-> data_cnt != '0 && data_cnt <= PAGE_BYTES;
  endproperty
  a_page_size: assert property (p_page_size) else $error("Page byte count out of range."); // [R06]

  property p_out_edge;
    $changed(so_o) |-> $past(sck_fall);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("Output moved off a falling edge."); // [R02]

  property p_standby;
    !selected && !busy |-> !power_active_o;
  endproperty
  a_standby: assert property (p_standby) else $error("Active while idle."); // [R10]

  c_commit: cover property (commit_go);
  c_sector: cover property (sector_go);
  c_status_write: cover property (write_status_cmd_go ##2 !busy);
  c_read_status: cover property (so_oe_o && sck_fall);

endmodule

// ===== tb/fwp_array_model.sv
// Array-side model that takes buffered operations and reports long ones done.
`timescale 1ns/1ps
module fwp_array_model
  import fwp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic op_valid_i,
  input fwp_pkg::fwp_op_type op_i,
  output logic op_ready_o,
  output logic array_done_o,
  output logic [7:0] prog_cnt_o,
  output logic [7:0] end_cnt_o,
  output logic [23:0] last_addr_o,
  output logic [7:0] last_data_o
);
  logic [5:0] wait_cnt;
  logic take;
  // Ready is withheld while the bench asks for a stall, so the buffer backs up.
  assign op_ready_o = !stall_i;
  assign take = op_valid_i && op_ready_o;
  // Counts program bytes and pulses done some cycles after a commit or erase.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 6'h00;
      array_done_o <= 1'b0;
      prog_cnt_o <= 8'h00;
      end_cnt_o <= 8'h00;
      last_addr_o <= 24'h000000;
      last_data_o <= 8'h00;
    end else begin
      array_done_o <= (wait_cnt == 6'h01);
      if (wait_cnt != 6'h00) begin
        wait_cnt <= wait_cnt - 6'h01;
      end
      if (take && op_i.kind == FWP_PROG_BYTE) begin
        prog_cnt_o <= prog_cnt_o + 8'h01;
        last_addr_o <= op_i.addr;
        last_data_o <= op_i.data;
      end
      if (take && op_i.kind != FWP_PROG_BYTE && op_i.kind != FWP_ABORT) begin
        end_cnt_o <= end_cnt_o + 8'h01;
        wait_cnt <= 6'h28;
      end
    end
  end
endmodule

// ===== tb/tb_spi_flash_write_protect_control.sv
// Self-checking bench that drives the serial host side and watches the array stream.
`timescale 1ns/1ps
module tb_spi_flash_write_protect_control;
  import fwp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic si = 1'b0;
  logic wp_n = 1'b1;
  logic stall = 1'b0;
  logic so, so_oe, op_valid, op_ready, done, pwr, dpd;
  fwp_op_type op;
  logic [7:0] status, pcnt, ecnt, s, ldata;
  logic [23:0] laddr;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  fwp_ctrl dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .write_protect_accel_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .op_valid_o(op_valid),
    .op_ready_i(op_ready), .op_o(op), .array_done_i(done), .status_o(status),
    .power_active_o(pwr), .deep_power_down_o(dpd));
  fwp_array_model array (.core_clk_i(core_clk_i), .rst_i(rst_i), .stall_i(stall),
    .op_valid_i(op_valid), .op_i(op), .op_ready_o(op_ready), .array_done_o(done),
    .prog_cnt_o(pcnt), .end_cnt_o(ecnt), .last_addr_o(laddr), .last_data_o(ldata));

  // Core clock of 50 ns.
  always #25 core_clk_i = ~core_clk_i;

  // Cuts a hung run short.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One selected frame of n bits, MSB first, serial clock 400 ns; rd keeps the last byte out.
  task automatic xfer(input logic [63:0] d, input int n, input bit m3, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge core_clk_i);
    #2;
    sck = m3;
    repeat (4) @(posedge core_clk_i);
    #2;
    cs_n = 1'b0;
    repeat (4) @(posedge core_clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      #2;
      sck = 1'b0;
      si = d[i];
      repeat (4) @(posedge core_clk_i);
      #2;
      sck = 1'b1;
      repeat (4) @(posedge core_clk_i);
      rd = {rd[6:0], so};
    end
    #2;
    sck = m3;
    repeat (2) @(posedge core_clk_i);
    #2;
    cs_n = 1'b1;
    repeat (8) @(posedge core_clk_i);
    #2;
  endtask

  task automatic cmd(input logic [7:0] c);
    xfer({56'h0, c}, 8, 1'b0, s);
  endtask

  task automatic rdsr(input bit m3);
    xfer({48'h0, DEF_READ_STATUS_CMD, 8'h00}, 16, m3, s);
  endtask

  // Polls the status byte until the busy flag drops.
  task automatic wait_idle();
    s = 8'h01;
    for (int k = 0; k < 30 && s[0] !== 1'b0; k++) begin
      rdsr(1'b0);
    end
    chk(s[0], 1'b0);
  endtask

  task automatic write_status_cmd(input logic [7:0] v);
    cmd(DEF_WRITE_ENABLE_CMD);
    xfer({48'h0, DEF_WRITE_STATUS_CMD, v}, 16, 1'b0, s);
    wait_idle();
  endtask

  // Main sequence of host frames with expected results.
  initial begin
    repeat (5) @(posedge core_clk_i);
    #2;
    rst_i = 1'b0;
    rdsr(1'b0);
    chk(s, 8'h00);
    chk({so_oe, pwr}, 2'b00);
    xfer({24'h0, DEF_PAGE_PROGRAM_CMD, 24'h000010, 8'hA5}, 40, 1'b0, s);
    chk({pcnt, ecnt, status}, 24'h000000);
    cmd(DEF_WRITE_ENABLE_CMD);
    rdsr(1'b1);
    chk(s, 8'h02);
    cmd(DEF_WRITE_DISABLE_CMD);
    rdsr(1'b0);
    chk(s, 8'h00);
    cmd(DEF_WRITE_ENABLE_CMD);
    stall = 1'b1;
    xfer({16'h0, DEF_PAGE_PROGRAM_CMD, 24'h000010, 16'hA53C}, 48, 1'b0, s);
    chk({op_valid, pwr, status[0], pcnt}, 11'h700);
    stall = 1'b0;
    wait_idle();
    chk({pcnt, ecnt, laddr, ldata, status}, 56'h0201_0000_113C_00);
    cmd(DEF_WRITE_ENABLE_CMD);
    xfer({31'h0, DEF_SECTOR_ERASE_CMD, 24'h040000, 1'b0}, 33, 1'b0, s);
    chk({ecnt, status}, 16'h0102);
    xfer({32'h0, DEF_SECTOR_ERASE_CMD, 24'h040000}, 32, 1'b0, s);
    wait_idle();
    chk({ecnt, s}, 16'h0200);
    write_status_cmd(8'h08);
    chk(s, 8'h08);
    cmd(DEF_WRITE_ENABLE_CMD);
    xfer({24'h0, DEF_PAGE_PROGRAM_CMD, 24'hF80000, 8'h00}, 40, 1'b0, s);
    chk({pcnt, ecnt, status}, 24'h02020A);
    xfer({24'h0, DEF_PAGE_PROGRAM_CMD, 24'hF7FFFF, 8'h00}, 40, 1'b0, s);
    wait_idle();
    chk({pcnt, ecnt, laddr, ldata}, 48'h0303_F7FFFF_00);
    chk({fwp_is_protected(24'hF80000, 4'h2, 1'b0), fwp_is_protected(24'hF7FFFF, 4'h2, 1'b0),
      fwp_is_protected(24'h000000, 4'h7, 1'b0)}, 3'b101);
    chk({fwp_is_protected(24'hFE0000, 4'h1, 1'b1), fwp_is_protected(24'hFDFFFF, 4'h1, 1'b1),
      fwp_is_protected(24'h000000, 4'h8, 1'b1)}, 3'b101);
    write_status_cmd(8'h88);
    wp_n = 1'b0;
    cmd(DEF_WRITE_ENABLE_CMD);
    xfer({48'h0, DEF_WRITE_STATUS_CMD, 8'h00}, 16, 1'b0, s);
    rdsr(1'b0);
    chk(s, 8'h8A);
    wp_n = 1'b1;
    write_status_cmd(8'h00);
    chk(s, 8'h00);
    cmd(DEF_WRITE_ENABLE_CMD);
    cmd(DEF_DEEP_POWER_DOWN_CMD);
    cmd(DEF_WRITE_ENABLE_CMD);
    xfer({32'h0, DEF_SECTOR_ERASE_CMD, 24'h000000}, 32, 1'b0, s);
    chk({dpd, ecnt, status[0]}, 10'h206);
    test_done();
  end
endmodule
